// ### hdl/ccdt_discard_timers.sv
// Discard timing for cached read-completion data held for PCI masters.
// Assumes hit, cycle-start and cache-fill strobes come from logic on clk;
// link and global reset arrive from pins and are synchronised here.
//
// Notes on behaviour
// - Count PCI cycle starts without hit; discard once count reaches limit.
// - Miss-limit check fires only after idle clocks reach the 12-bit floor.
// - Discard when idle clocks without a hit reach the 12-bit ceiling.
// - Transfer limit upper byte always reads zero.
// - Floor and ceiling top four bits always read zero.
// - Link, global and power-on reset restore all three limits to defaults.
// - Transfer limit also reachable at configuration alias, same storage.
// - Three limits sit at successive 16-bit window offsets from 52h.
`timescale 1ns/1ps
module ccdt_discard_timers
	import ccdt_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic link_reset_in,
	input wire logic global_reset_in,
	input wire logic pci_cycle_start,
	input wire logic read_hit,
	input wire logic data_cached,
	input wire logic [7:0] win_addr,
	input wire logic win_wr,
	input wire logic win_rd,
	input wire logic [15:0] win_wdata,
	output logic [15:0] win_rdata_ff,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata_ff,
	output logic discard_ff,
	output logic miss_check_armed_ff,
	output logic data_held_ff
);
	// ----------------------------------------------------------------
	// Reset pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] link_sync_ff;
	logic [1:0] glob_sync_ff;
	logic fld_rst;

	// Two stages each; only the second stage is looked at
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			link_sync_ff <= 2'h0;
			glob_sync_ff <= 2'h0;
		end
		else
		begin
			link_sync_ff <= {link_sync_ff[0], link_reset_in};
			glob_sync_ff <= {glob_sync_ff[0], global_reset_in};
		end
	end
	assign fld_rst = link_sync_ff[1] | glob_sync_ff[1];

	// ----------------------------------------------------------------
	// Limit registers
	// ----------------------------------------------------------------
	logic [7:0] xfr_limit_ff;
	logic [11:0] floor_ff;
	logic [11:0] ceil_ff;
	logic [7:0] nxt_xfr_limit;
	logic [11:0] nxt_floor;
	logic [11:0] nxt_ceil;

	// Window write beats the alias write when both hit the same cycle
	always_comb
	begin
		nxt_xfr_limit = xfr_limit_ff;
		nxt_floor = floor_ff;
		nxt_ceil = ceil_ff;
		if (fld_rst)
		begin
			nxt_xfr_limit = CCDT_RST_XFR_LIMIT;
			nxt_floor = CCDT_RST_IDLE_FLOOR;
			nxt_ceil = CCDT_RST_IDLE_CEIL;
		end
		else
		begin
			if (cfg_wr && cfg_addr == CCDT_OFS_CFG_ALIAS)
				nxt_xfr_limit = cfg_wdata;
			if (win_wr)
			begin
				unique case (win_addr)
					CCDT_OFS_XFR_LIMIT: nxt_xfr_limit = win_wdata[7:0];
					CCDT_OFS_IDLE_FLOOR: nxt_floor = win_wdata[11:0];
					CCDT_OFS_IDLE_CEIL: nxt_ceil = win_wdata[11:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			xfr_limit_ff <= CCDT_RST_XFR_LIMIT;
			floor_ff <= CCDT_RST_IDLE_FLOOR;
			ceil_ff <= CCDT_RST_IDLE_CEIL;
		end
		else
		begin
			xfr_limit_ff <= nxt_xfr_limit;
			floor_ff <= nxt_floor;
			ceil_ff <= nxt_ceil;
		end
	end

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	logic [15:0] nxt_win_rdata;
	logic [7:0] nxt_cfg_rdata;

	// Reserved bits padded with zero; unmapped offsets read zero
	always_comb
	begin
		nxt_win_rdata = win_rdata_ff;
		nxt_cfg_rdata = cfg_rdata_ff;
		if (win_rd)
		begin
			unique case (win_addr)
				CCDT_OFS_XFR_LIMIT: nxt_win_rdata = {8'h00, xfr_limit_ff};
				CCDT_OFS_IDLE_FLOOR: nxt_win_rdata = {4'h0, floor_ff};
				CCDT_OFS_IDLE_CEIL: nxt_win_rdata = {4'h0, ceil_ff};
				default: nxt_win_rdata = 16'h0000;
			endcase
		end
		if (cfg_rd)
			nxt_cfg_rdata = (cfg_addr == CCDT_OFS_CFG_ALIAS) ? xfr_limit_ff : 8'h00;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			win_rdata_ff <= 16'h0000;
			cfg_rdata_ff <= 8'h00;
		end
		else
		begin
			win_rdata_ff <= nxt_win_rdata;
			cfg_rdata_ff <= nxt_cfg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Idle and cycle-start counters, discard decision
	// ----------------------------------------------------------------
	ccdt_state_t state_ff;
	ccdt_state_t nxt_state;
	logic [11:0] idle_cnt_ff;
	logic [11:0] nxt_idle_cnt;
	logic [7:0] start_cnt_ff;
	logic [7:0] nxt_start_cnt;
	logic nxt_discard;
	logic nxt_armed;
	logic floor_met;
	logic xfr_met;
	logic ceil_met;

	assign floor_met = idle_cnt_ff >= floor_ff;
	assign xfr_met = start_cnt_ff >= xfr_limit_ff;
	assign ceil_met = idle_cnt_ff >= ceil_ff;

	// Counters saturate so a long idle spell cannot wrap below a limit
	always_comb
	begin
		nxt_state = state_ff;
		nxt_idle_cnt = idle_cnt_ff;
		nxt_start_cnt = start_cnt_ff;
		nxt_discard = 1'b0;
		unique case (state_ff)
			CCDT_EMPTY:
			begin
				nxt_idle_cnt = 12'h000;
				nxt_start_cnt = 8'h00;
				if (data_cached)
					nxt_state = CCDT_HELD;
			end
			CCDT_HELD:
			begin
				if (read_hit || data_cached)
				begin
					nxt_idle_cnt = 12'h000;
					nxt_start_cnt = 8'h00;
				end
				else if ((xfr_met && floor_met) || ceil_met)
				begin
					nxt_discard = 1'b1;
					nxt_state = CCDT_EMPTY;
				end
				else
				begin
					if (idle_cnt_ff != 12'hFFF)
						nxt_idle_cnt = idle_cnt_ff + 12'h001;
					if (pci_cycle_start && start_cnt_ff != 8'hFF)
						nxt_start_cnt = start_cnt_ff + 8'h01;
				end
			end
		endcase
		nxt_armed = (nxt_state == CCDT_HELD) && (nxt_idle_cnt >= floor_ff);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= CCDT_EMPTY;
			idle_cnt_ff <= 12'h000;
			start_cnt_ff <= 8'h00;
			discard_ff <= 1'b0;
			miss_check_armed_ff <= 1'b0;
			data_held_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			idle_cnt_ff <= nxt_idle_cnt;
			start_cnt_ff <= nxt_start_cnt;
			discard_ff <= nxt_discard;
			miss_check_armed_ff <= nxt_armed;
			data_held_ff <= (nxt_state == CCDT_HELD);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_xfr_discard;
		@(posedge clk) disable iff (reset)
		(state_ff == CCDT_HELD && !read_hit && !data_cached && xfr_met && floor_met)
		|=> discard_ff && !data_held_ff;
	endproperty
	a_xfr_discard: assert property (p_xfr_discard) else $error("start limit discard missed");

	property p_floor_gate;
		@(posedge clk) disable iff (reset)
		(discard_ff && !$past(ceil_met)) |-> $past(floor_met) && $past(xfr_met);
	endproperty
	a_floor_gate: assert property (p_floor_gate) else $error("discard before idle floor");

	property p_ceil_discard;
		@(posedge clk) disable iff (reset)
		(state_ff == CCDT_HELD && !read_hit && !data_cached && ceil_met) |=> discard_ff;
	endproperty
	a_ceil_discard: assert property (p_ceil_discard) else $error("ceiling discard missed");

	property p_xfr_rsvd;
		@(posedge clk) disable iff (reset)
		(win_rd && win_addr == CCDT_OFS_XFR_LIMIT) |=> win_rdata_ff[15:8] == 8'h00;
	endproperty
	a_xfr_rsvd: assert property (p_xfr_rsvd) else $error("transfer limit upper byte nonzero");

	property p_idle_rsvd;
		@(posedge clk) disable iff (reset)
		(win_rd && (win_addr == CCDT_OFS_IDLE_FLOOR || win_addr == CCDT_OFS_IDLE_CEIL))
		|=> win_rdata_ff[15:12] == 4'h0;
	endproperty
	a_idle_rsvd: assert property (p_idle_rsvd) else $error("idle limit top bits nonzero");

	property p_fld_rst;
		@(posedge clk) disable iff (reset)
		fld_rst |=> xfr_limit_ff == CCDT_RST_XFR_LIMIT && floor_ff == CCDT_RST_IDLE_FLOOR
			&& ceil_ff == CCDT_RST_IDLE_CEIL;
	endproperty
	a_fld_rst: assert property (p_fld_rst) else $error("limits not restored");

	property p_alias;
		@(posedge clk) disable iff (reset)
		(cfg_wr && cfg_addr == CCDT_OFS_CFG_ALIAS && !fld_rst && !win_wr) ##1 win_rd
			&& win_addr == CCDT_OFS_XFR_LIMIT && !win_wr && !fld_rst
		|=> win_rdata_ff[7:0] == $past(cfg_wdata, 2);
	endproperty
	a_alias: assert property (p_alias) else $error("alias storage mismatch");

	property p_floor_wr;
		@(posedge clk) disable iff (reset)
		(win_wr && win_addr == CCDT_OFS_IDLE_FLOOR && !fld_rst) |=> floor_ff == $past(win_wdata[11:0]);
	endproperty
	a_floor_wr: assert property (p_floor_wr) else $error("floor write lost");

	property p_restart;
		@(posedge clk) disable iff (reset)
		(read_hit || data_cached) |=> idle_cnt_ff == 12'h000 && start_cnt_ff == 8'h00 && !discard_ff;
	endproperty
	a_restart: assert property (p_restart) else $error("counters not restarted");

	c_ceil: cover property (@(posedge clk) disable iff (reset) ceil_met && discard_ff == 1'b0 ##1 discard_ff);
	c_xfr: cover property (@(posedge clk) disable iff (reset) !ceil_met && xfr_met ##1 discard_ff);
	c_hit: cover property (@(posedge clk) disable iff (reset) data_held_ff && read_hit);
endmodule

// ### pkg/ccdt_pkg.sv
// Constants for the completion cache discard timers.
// Assumes 16-bit register locations in the device control memory window.
package ccdt_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CCDT_OFS_XFR_LIMIT = 8'h52;
	localparam logic [7:0] CCDT_OFS_IDLE_FLOOR = 8'h54;
	localparam logic [7:0] CCDT_OFS_IDLE_CEIL = 8'h56;
	localparam logic [7:0] CCDT_OFS_CFG_ALIAS = 8'hEA;
	// ----------------------------------------------------------------
	// Field widths and reset values
	// ----------------------------------------------------------------
	localparam int CCDT_XFR_W = 8;
	localparam int CCDT_IDLE_W = 12;
	localparam logic [7:0] CCDT_RST_XFR_LIMIT = 8'h08;
	localparam logic [11:0] CCDT_RST_IDLE_FLOOR = 12'h07F;
	localparam logic [11:0] CCDT_RST_IDLE_CEIL = 12'h1C0;
	// ----------------------------------------------------------------
	// Holding state
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		CCDT_EMPTY = 1'b0,
		CCDT_HELD = 1'b1
	} ccdt_state_t;
endpackage

// ### tb/ccdt_pci_master.sv
// PCI master side model: cycle starts, read hits, cache fills.
// Assumes its task is called from a bench process on clk.
`timescale 1ns/1ps
module ccdt_pci_master
(
	input wire logic clk,
	output logic pci_cycle_start,
	output logic read_hit,
	output logic data_cached
);
	// --------------------
	// Strobes
	// --------------------
	initial
	begin
		pci_cycle_start = 1'b0;
		read_hit = 1'b0;
		data_cached = 1'b0;
	end
	// One-clock strobe off the falling edge: 0 start, 1 hit, 2 fill
	task automatic pulse(input int k);
		@(negedge clk);
		pci_cycle_start = (k == 0);
		read_hit = (k == 1);
		data_cached = (k == 2);
		@(negedge clk);
		pci_cycle_start = 1'b0;
		read_hit = 1'b0;
		data_cached = 1'b0;
	endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the completion cache discard timers.
// Assumes a 50 ns clock; PCI side strobes come from the master model.
`timescale 1ns/1ps
module testbench
	import ccdt_pkg::*;
;
	// --------------------
	// Stimulus and hookup
	// --------------------
	logic clk = 1'b0, reset = 1'b1, lrst = 1'b0, gbl_rst = 1'b0;
	logic wr = 1'b0, rd = 1'b0, cwr = 1'b0, crd = 1'b0;
	logic [7:0] addr = 8'h00, caddr = 8'h00, cwd = 8'h00, crdata;
	logic [15:0] wd = 16'h0000, rdata;
	logic disc, armed, held, st, hit, fill;
	int miscompares = 0, total_checks = 0;
	always #25 clk = ~clk;
	ccdt_pci_master pm(.clk(clk), .pci_cycle_start(st), .read_hit(hit), .data_cached(fill));
	ccdt_discard_timers uut(.clk(clk), .reset(reset), .link_reset_in(lrst),
		.global_reset_in(gbl_rst), .pci_cycle_start(st), .read_hit(hit), .data_cached(fill),
		.win_addr(addr), .win_wr(wr), .win_rd(rd), .win_wdata(wd), .win_rdata_ff(rdata),
		.cfg_addr(caddr), .cfg_wr(cwr), .cfg_rd(crd), .cfg_wdata(cwd), .cfg_rdata_ff(crdata),
		.discard_ff(disc), .miss_check_armed_ff(armed), .data_held_ff(held));
	// --------------------
	// Shared tasks
	// --------------------
	task automatic chk(input logic [15:0] g, e);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// Read data lands on the taking edge, so it is settled by the next fall
	task automatic rreg(input logic [7:0] a, input logic [15:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(rdata, e);
	endtask
	// An alias write is read back through the window on the very next edge
	task automatic alias_acc(input logic w, input logic [7:0] d);
		@(negedge clk);
		caddr = 8'hEA;
		cwd = d;
		cwr = w;
		crd = !w;
		@(negedge clk);
		cwr = 1'b0;
		crd = 1'b0;
		addr = 8'h52;
		rd = w;
		@(negedge clk);
		rd = 1'b0;
		if (w)
			chk(rdata, {8'h00, d});
		else
			chk({8'h00, crdata}, {8'h00, d});
	endtask
	task automatic limits(input logic [15:0] x, f, c);
		wreg(8'h52, x);
		wreg(8'h54, f);
		wreg(8'h56, c);
	endtask
	// Strobe, then count falling edges up to the discard pulse
	task automatic timed(input int k, input int n);
		int i;
		pm.pulse(k);
		i = 0;
		while (disc !== 1'b1 && i < 200)
		begin
			@(negedge clk);
			i++;
		end
		if (i >= 200)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: no discard", $time);
			finish_test();
		end
		else
		begin
			chk(16'(i), 16'(n));
			chk({15'h0000, held}, 16'h0000);
		end
	endtask
	// Data must stay held, no discard, armed flag as the floor dictates
	task automatic quiet(input int n, input logic a);
		repeat (n)
		begin
			@(negedge clk);
			chk({13'h0000, held, armed, disc}, {13'h0000, 1'b1, a, 1'b0});
		end
	endtask
	// --------------------
	// Scenarios
	// --------------------
	task automatic t_regs();
		rreg(8'h52, 16'h0008);
		rreg(8'h54, 16'h007F);
		rreg(8'h56, 16'h01C0);
		rreg(8'h58, 16'h0000);
		alias_acc(1'b0, 8'h08);
		limits(16'hFFFF, 16'hFFFF, 16'hFFFF);
		rreg(8'h52, 16'h00FF);
		alias_acc(1'b0, 8'hFF);
		rreg(8'h54, 16'h0FFF);
		rreg(8'h56, 16'h0FFF);
		alias_acc(1'b1, 8'h20);
		rreg(8'h52, 16'h0020);
		$display("register test done");
	endtask
	// Fill and hit both restart idle time: discard shows limit+1 falls after strobe drops
	task automatic t_timing();
		limits(16'h00FF, 16'h0FFF, 16'h0005);
		timed(2, 6);
		limits(16'h0000, 16'h0006, 16'h0FFF);
		timed(2, 7);
		limits(16'h00FF, 16'h0FFF, 16'h0005);
		pm.pulse(2);
		quiet(4, 1'b0);
		timed(1, 6);
		$display("timer test done");
	endtask
	task automatic t_starts();
		limits(16'h0002, 16'h0000, 16'h0FFF);
		pm.pulse(2);
		quiet(20, 1'b1);
		pm.pulse(0);
		quiet(4, 1'b1);
		timed(0, 1);
		$display("cycle start test done");
	endtask
	// Pin resets pass a two-stage sync, so allow a few clocks after release;
	// the last pass pulses the power-on reset in mid-run
	task automatic t_pins();
		for (int p = 0; p < 3; p++)
		begin
			limits(16'h0011, 16'h0022, 16'h0033);
			@(negedge clk);
			lrst = (p == 0);
			gbl_rst = (p == 1);
			reset = (p == 2);
			repeat (4) @(negedge clk);
			lrst = 1'b0;
			gbl_rst = 1'b0;
			reset = 1'b0;
			repeat (3) @(negedge clk);
			rreg(8'h52, 16'h0008);
			rreg(8'h54, 16'h007F);
			rreg(8'h56, 16'h01C0);
		end
		$display("pin reset test done");
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		t_regs();
		t_timing();
		t_starts();
		t_pins();
		finish_test();
	end
endmodule
